/* rtl/ecp_pkg.sv */
/*
 * Shared constants, register map and carrier types for the enhanced
 * capture/compare/PWM block.
 * Assumes a 32-bit APB master and a 10 MHz system clock.
 */
package ecp_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL1   = 8'h00; // Unit one control
    localparam logic [7:0] ADDR_CTRL2   = 8'h04; // Unit two control
    localparam logic [7:0] ADDR_CTRL3   = 8'h08; // Unit three control
    localparam logic [7:0] ADDR_CMP1    = 8'h0C; // Unit one compare pair
    localparam logic [7:0] ADDR_CMP2    = 8'h10; // Unit two compare pair
    localparam logic [7:0] ADDR_DUTY    = 8'h14; // Unit three duty low
    localparam logic [7:0] ADDR_PERIOD  = 8'h18; // Period register
    localparam logic [7:0] ADDR_T3CTL   = 8'h1C; // Third timer control
    localparam logic [7:0] ADDR_TIMER1  = 8'h20; // First timer (r/w)
    localparam logic [7:0] ADDR_TIMER3  = 8'h24; // Third timer (r/w)
    localparam logic [7:0] ADDR_STATUS  = 8'h28; // Status (read only)
    localparam logic [7:0] ADDR_DEADBND = 8'h2C; // Dead-band delay
    localparam logic [7:0] ADDR_MISC    = 8'h30; // Prescale, enables

    // Control field positions
    localparam int OCFG_HI = 7;
    localparam int OCFG_LO = 6;
    localparam int DLSB_HI = 5;
    localparam int DLSB_LO = 4;
    localparam int MODE_HI = 3;
    localparam int MODE_LO = 0;

    // Mode field codes
    localparam logic [3:0] MODE_CMP_SWI = 4'hA;
    localparam logic [3:0] MODE_CMP_SET = 4'hB;
    localparam logic [1:0] PWM_MODE_TOP = 2'h3; // Codes 11xx are PWM
    localparam logic [3:0] POL_BIT_AH   = 4'h0; // 1100: all active high

    // Third timer control: bit 3 selects timer three for compare,
    // bit 6 selects the alternate PWM time base
    localparam int T3_CMPSEL_BIT = 3;
    localparam int T3_PWMSEL_BIT = 6;

    // Misc register: bits 1:0 prescale, bit 2 converter enable,
    // bits 4:3 timer enables
    localparam int MISC_ADEN_BIT = 2;
    localparam int MISC_T1EN_BIT = 3;
    localparam int MISC_T3EN_BIT = 4;

    // Prescale counts of 1, 4 and 16
    localparam logic [3:0] PRE_1  = 4'h0;
    localparam logic [3:0] PRE_4  = 4'h3;
    localparam logic [3:0] PRE_16 = 4'hF;

    localparam logic [7:0]  RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // Output configuration codes
    typedef enum logic [1:0] {
        OC_SINGLE = 2'b00,
        OC_FWD    = 2'b01,
        OC_HALF   = 2'b10,
        OC_REV    = 2'b11
    } ecp_ocfg_t;

    // Buffered PWM settings, loaded together at the period boundary
    typedef struct packed {
        logic [9:0] duty;
        ecp_ocfg_t  ocfg;
        logic [1:0] pol;
        logic       run;
    } ecp_pwm_set_t;
endpackage

/* rtl/ecp_top.sv */
/*
 * Enhanced capture/compare/PWM block: special event trigger compare for
 * units one and two, and a four-output enhanced PWM on unit three.
 * Assumes an APB master on CLK and pins already set as outputs by
 * software; the standard unit four output arrives as a same-clock input.
 */
// Decided for this implementation: the placing of the registers and the APB register port.
// Operation
// R1: Quad PWM output D overrides standard unit four
// R2: Output config bits 7:6, mode bits 3:0
// R3: Units one, two trigger on compare match
// R4: Trigger mode code is 1011
// R5: Trigger resets selected first/third timer
// R6: Unit two trigger starts conversion if enabled
// R7: Other units treat 1011 as 1010
// R8: Unit two trigger sets no timer flag
// R9: Four outputs A-D, selectable polarity
// R10: Time base chosen by third timer control
// R11: PWM settings double-buffered at period boundary
// R12: Dead-band loads at first duty or period edge
// R13: PWM starts only after timer reset
// R14: Software clears pin direction bits itself
// R15: Period is (period+1)*4*Tosc*prescale
// R16: On period match clear timer, set output, copy duty
// R17: Postscaler does not affect PWM period
// R18: Duty is ten bits, low bits control 5:4
// R19: Clear output on duty match, never beyond period
// R20: Output config selects single, half, forward, reverse
// R21: Prescale is 1, 4 or 16
`timescale 1ns/1ns
module ecp_top (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        CE,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        STD4_OUT,
    output logic             STD4_PIN,
    output logic [3:0]       PWM_OUT,
    output logic             TRIG_ONE,
    output logic             TRIG_TWO,
    output logic             ADC_START,
    output logic             FIRST_TIMER_IF,
    output logic             THIRD_TIMER_IF
);
    logic [7:0]  ctrl [3];
    logic [15:0] cmp [2];
    logic [7:0]  duty_low;
    logic [7:0]  period_reg;
    logic [7:0]  t3ctl;
    logic [7:0]  misc;
    logic [6:0]  deadband;
    logic [6:0]  deadband_act;
    logic [15:0] first_timer;
    logic [15:0] third_timer;
    logic [7:0]  pwm_timebase;
    logic [7:0]  alt_pwm_timebase;
    logic [3:0]  pre_cnt;
    logic [1:0]  qclk;
    logic [7:0]  duty_buffer_reg;
    logic [1:0]  duty_latch;
    logic        pwm_level;
    ecp_pkg::ecp_pwm_set_t act;
    logic [1:0]  trig;
    logic        wr_en;
    logic        rd_en;
    logic        hit;
    logic [31:0] rdata;

    // Bus strobes: zero-wait slave, every access done in one access cycle
    assign wr_en = CE && PSEL && PENABLE && PWRITE;
    assign rd_en = CE && PSEL && PENABLE && !PWRITE;

    // Register write port
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            for (int i = 0; i < 3; i++) ctrl[i] <= ecp_pkg::RESET_BYTE;
            cmp[0]     <= ecp_pkg::RESET_WORD;
            cmp[1]     <= ecp_pkg::RESET_WORD;
            duty_low   <= ecp_pkg::RESET_BYTE;
            period_reg <= ecp_pkg::RESET_BYTE;
            t3ctl      <= ecp_pkg::RESET_BYTE;
            misc       <= ecp_pkg::RESET_BYTE;
            deadband   <= 7'h00;
        end else if (wr_en) begin
            case (PADDR)
                ecp_pkg::ADDR_CTRL1:   ctrl[0] <= PWDATA[7:0]; // R2
                ecp_pkg::ADDR_CTRL2:   ctrl[1] <= PWDATA[7:0];
                ecp_pkg::ADDR_CTRL3:   ctrl[2] <= PWDATA[7:0];
                ecp_pkg::ADDR_CMP1:    cmp[0] <= PWDATA[15:0];
                ecp_pkg::ADDR_CMP2:    cmp[1] <= PWDATA[15:0];
                ecp_pkg::ADDR_DUTY:    duty_low <= PWDATA[7:0]; // R18
                ecp_pkg::ADDR_PERIOD:  period_reg <= PWDATA[7:0];
                ecp_pkg::ADDR_T3CTL:   t3ctl <= PWDATA[7:0];
                ecp_pkg::ADDR_MISC:    misc <= PWDATA[7:0];
                ecp_pkg::ADDR_DEADBND: deadband <= PWDATA[6:0];
                default: ;
            endcase
        end
    end

    // Read mux; unmapped addresses read zero and flag an error
    always_comb begin
        rdata = 32'h0000_0000;
        hit   = 1'b1;
        case (PADDR)
            ecp_pkg::ADDR_CTRL1:   rdata[7:0]  = ctrl[0];
            ecp_pkg::ADDR_CTRL2:   rdata[7:0]  = ctrl[1];
            ecp_pkg::ADDR_CTRL3:   rdata[7:0]  = ctrl[2];
            ecp_pkg::ADDR_CMP1:    rdata[15:0] = cmp[0];
            ecp_pkg::ADDR_CMP2:    rdata[15:0] = cmp[1];
            ecp_pkg::ADDR_DUTY:    rdata[17:0] = {duty_latch, duty_buffer_reg, duty_low};
            ecp_pkg::ADDR_PERIOD:  rdata[7:0]  = period_reg;
            ecp_pkg::ADDR_T3CTL:   rdata[7:0]  = t3ctl;
            ecp_pkg::ADDR_TIMER1:  rdata[15:0] = first_timer;
            ecp_pkg::ADDR_TIMER3:  rdata[15:0] = third_timer;
            ecp_pkg::ADDR_STATUS:  rdata[3:0]  = {act.run, THIRD_TIMER_IF, FIRST_TIMER_IF, pwm_level};
            ecp_pkg::ADDR_DEADBND: rdata[6:0]  = deadband_act;
            ecp_pkg::ADDR_MISC:    rdata[7:0]  = misc;
            default:               hit = 1'b0;
        endcase
    end

    // Registered bus answer, so outputs come from flops
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            PRDATA  <= 32'h0000_0000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else if (CE) begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE && !hit;
            if (PSEL && !PENABLE) PRDATA <= rdata;
        end
    end

    // Compare trigger per enhanced unit one and two; units three and the
    // standard units have no trigger, so 1011 acts as plain compare there
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_trig
            logic [15:0] sel_t;
            assign sel_t = t3ctl[ecp_pkg::T3_CMPSEL_BIT] ? third_timer : first_timer;
            assign trig[g] = (ctrl[g][ecp_pkg::MODE_HI:ecp_pkg::MODE_LO]
                              == ecp_pkg::MODE_CMP_SET) && (cmp[g] == sel_t); // R3 R4 R7
        end
    endgenerate

    // Trigger and conversion pulses
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            TRIG_ONE  <= 1'b0;
            TRIG_TWO  <= 1'b0;
            ADC_START <= 1'b0;
        end else if (CE) begin
            TRIG_ONE  <= trig[0];
            TRIG_TWO  <= trig[1];
            ADC_START <= trig[1] && misc[ecp_pkg::MISC_ADEN_BIT]; // R6
        end
    end

    // 16-bit timers; trigger resets the selected one, overflow sets its flag.
    // The flag is sticky and cleared by writing the timer.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            first_timer <= ecp_pkg::RESET_WORD;
            third_timer <= ecp_pkg::RESET_WORD;
            FIRST_TIMER_IF     <= 1'b0;
            THIRD_TIMER_IF     <= 1'b0;
        end else if (CE) begin
            if (wr_en && PADDR == ecp_pkg::ADDR_TIMER1) begin
                first_timer <= PWDATA[15:0];
                FIRST_TIMER_IF     <= 1'b0;
            end else if ((|trig) && !t3ctl[ecp_pkg::T3_CMPSEL_BIT]) begin
                first_timer <= ecp_pkg::RESET_WORD; // R5 R8
            end else if (misc[ecp_pkg::MISC_T1EN_BIT]) begin
                first_timer <= first_timer + 16'h0001;
                if (&first_timer) FIRST_TIMER_IF <= 1'b1;
            end
            if (wr_en && PADDR == ecp_pkg::ADDR_TIMER3) begin
                third_timer <= PWDATA[15:0];
                THIRD_TIMER_IF     <= 1'b0;
            end else if ((|trig) && t3ctl[ecp_pkg::T3_CMPSEL_BIT]) begin
                third_timer <= ecp_pkg::RESET_WORD; // R5 R8
            end else if (misc[ecp_pkg::MISC_T3EN_BIT]) begin
                third_timer <= third_timer + 16'h0001;
                if (&third_timer) THIRD_TIMER_IF <= 1'b1;
            end
        end
    end

    // PWM time base: one Q step per prescale count of clocks, one timer tick per four Q steps,
    // so four clocks times prescale. One clock stands for one Tosc here.
    logic [3:0] pre_max;
    logic       q_wrap;
    logic       tick;
    logic       alt_sel;
    logic [7:0] tb;
    logic       pwm_mode;
    logic       at_period;
    assign pre_max = (misc[1:0] == 2'b00) ? ecp_pkg::PRE_1 :
                     (misc[1:0] == 2'b01) ? ecp_pkg::PRE_4 : ecp_pkg::PRE_16; // R21
    assign q_wrap    = (pre_cnt == pre_max);
    assign tick      = q_wrap && (qclk == 2'b11); // R15 R17
    assign alt_sel   = t3ctl[ecp_pkg::T3_PWMSEL_BIT]; // R10
    assign tb        = alt_sel ? alt_pwm_timebase : pwm_timebase;
    assign pwm_mode  = ctrl[2][ecp_pkg::MODE_HI:ecp_pkg::MODE_HI-1] == ecp_pkg::PWM_MODE_TOP;
    assign at_period = tick && (tb == period_reg);

    // Prescale counter and Q clock
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            pre_cnt <= 4'h0;
            qclk    <= 2'b00;
        end else if (CE) begin
            if (q_wrap) begin
                pre_cnt <= 4'h0;
                qclk    <= qclk + 2'b01;
            end else begin
                pre_cnt <= pre_cnt + 4'h1;
            end
        end
    end

    // Both time bases share the prescaler; the unselected one idles
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            pwm_timebase     <= ecp_pkg::RESET_BYTE;
            alt_pwm_timebase <= ecp_pkg::RESET_BYTE;
        end else if (CE && tick) begin
            if (!alt_sel) pwm_timebase <= at_period ? 8'h00 : pwm_timebase + 8'h01; // R16
            if (alt_sel) alt_pwm_timebase <= at_period ? 8'h00 : alt_pwm_timebase + 8'h01;
        end
    end

    // Double buffer: duty, output config, polarity and run load only at the period boundary, so the
    // module cannot start mid-period and lags standard PWM by one cycle
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            act             <= '0;
            duty_buffer_reg <= ecp_pkg::RESET_BYTE;
            duty_latch      <= 2'b00;
        end else if (CE && at_period) begin
            act.duty <= {duty_low, ctrl[2][ecp_pkg::DLSB_HI:ecp_pkg::DLSB_LO]}; // R11 R18
            act.ocfg <= ecp_pkg::ecp_ocfg_t'(ctrl[2][ecp_pkg::OCFG_HI:ecp_pkg::OCFG_LO]);
            act.pol  <= ctrl[2][1:0];
            act.run  <= pwm_mode; // R13
            duty_buffer_reg <= duty_low; // R16
            duty_latch      <= ctrl[2][ecp_pkg::DLSB_HI:ecp_pkg::DLSB_LO];
        end
    end

    // Dead-band loads at both the period and the duty boundary. The match is taken
    // at the end of the Q step before the duty count, so the registered
    // level falls exactly duty Q steps after the period start
    logic duty_hit;
    assign duty_hit = ({tb, qclk} == (act.duty - 10'h001)) && q_wrap; // R19
    always_ff @(posedge CLK) begin
        if (!RESET_N) deadband_act <= 7'h00;
        else if (CE && (at_period || duty_hit)) deadband_act <= deadband; // R12
    end

    // Raw PWM level: set at period start unless duty is zero, cleared on
    // duty match; a duty beyond the period never matches
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            pwm_level <= 1'b0;
        end else if (CE) begin
            if (at_period) begin
                pwm_level <= pwm_mode
                    && ({duty_low, ctrl[2][ecp_pkg::DLSB_HI:ecp_pkg::DLSB_LO]} != 10'h000); // R16
            end else if (act.run && duty_hit) begin
                pwm_level <= 1'b0; // R19
            end
        end
    end

    // Output steering per configuration and polarity; pol bit 1 inverts
    // A and C, bit 0 inverts B and D
    logic [3:0] act_lvl;
    always_comb begin
        act_lvl = 4'b0000;
        if (act.run) begin
            case (act.ocfg)
                ecp_pkg::OC_SINGLE: act_lvl = {3'b000, pwm_level};
                ecp_pkg::OC_HALF:   act_lvl = {2'b00, !pwm_level, pwm_level};
                ecp_pkg::OC_FWD:    act_lvl = {pwm_level, 2'b00, 1'b1};
                ecp_pkg::OC_REV:    act_lvl = {1'b0, 1'b1, pwm_level, 1'b0};
                default:            act_lvl = 4'b0000;
            endcase // R9 R20
        end
    end

    // Output flops, including the pin shared with standard unit four
    logic quad;
    assign quad = act.run && act.ocfg[0];
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            PWM_OUT  <= 4'b0000;
            STD4_PIN <= 1'b0;
        end else if (CE) begin
            PWM_OUT  <= act_lvl ^ {act.pol[0], act.pol[1], act.pol[0], act.pol[1]}; // R9
            STD4_PIN <= quad ? (act_lvl[3] ^ act.pol[0]) : STD4_OUT; // R1
        end
    end
endmodule // ecp_top

/* tb/ecp_chk.sv */
/* Checker for ecp_top: bus answer timing, trigger side effects, flags.
   Assumes one clock and a synchronous active-low reset; bound below. */
`timescale 1ns/1ns
module ecp_chk (
    input wire logic       CLK,
    input wire logic       RESET_N,
    input wire logic       CE,
    input wire logic       PSEL,
    input wire logic       PENABLE,
    input wire logic       PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic       PREADY,
    input wire logic       PSLVERR,
    input wire logic [3:0] PWM_OUT,
    input wire logic       TRIG_ONE,
    input wire logic       TRIG_TWO,
    input wire logic       ADC_START,
    input wire logic       FIRST_TIMER_IF
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    // Bus answer: one cycle after setup, one cycle long, only in access
    a_ready_next: assert property (PSEL && !PENABLE && CE |=> PREADY)
        else $error("ready missing after setup");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    a_ready_access: assert property (PREADY |-> PSEL && PENABLE)
        else $error("ready outside access");
    a_err_unmapped: assert property (PSLVERR |-> PREADY && (PADDR > 8'h30 || PADDR[1:0] != 2'h0))
        else $error("error on a mapped address");
    // Converter start only ever comes with the unit two trigger
    a_adc_trig: assert property (ADC_START |-> TRIG_TWO)
        else $error("converter start without trigger");
    // Timer flag: never raised by a trigger reset, cleared only by a timer write
    a_trig_noflag: assert property ($rose(FIRST_TIMER_IF) |-> !$past(TRIG_TWO) && !$past(TRIG_ONE))
        else $error("trigger reset set the timer flag");
    a_flag_clear: assert property ($fell(FIRST_TIMER_IF) |-> $past(PSEL && PENABLE && PWRITE && PREADY && PADDR == ecp_pkg::ADDR_TIMER1))
        else $error("flag dropped without a timer write");
    // Clock enable low freezes the pins, so a stall never glitches a leg
    a_ce_freeze: assert property (!CE |=> $stable(PWM_OUT) && $stable(FIRST_TIMER_IF))
        else $error("state moved with clock enable low");
    // Pins are quiet after every reset edge, reset itself not masking it
    a_reset_quiet: assert property (disable iff (1'b0) !RESET_N |=> PWM_OUT == 4'h0 && !TRIG_ONE && !TRIG_TWO && !FIRST_TIMER_IF)
        else $error("outputs active after reset");

    cover property (TRIG_ONE);
    cover property (ADC_START);
    cover property (PSLVERR);
    cover property ($fell(FIRST_TIMER_IF));
endmodule // ecp_chk

bind ecp_top ecp_chk ecp_chk_i (.*);

/* tb/ecp_bridge.sv */
/* Bridge switch driver model: times leg A between its edges.
   Assumes legs are driven pins (directions set by software). */
`timescale 1ns/1ns
module ecp_bridge (
    input wire logic       clk,
    input wire logic [3:0] leg,
    output int             per,
    output int             hi
);
    int   cnt  = 0;
    logic last = 1'b0;

    // Edge to edge only, so the start-up phase of the time base is irrelevant
    always @(posedge clk) begin
        cnt  <= cnt + 1;
        last <= leg[0];
        if (leg[0] && !last) begin
            per <= cnt;
            cnt <= 1;
        end
        if (!leg[0] && last) hi <= cnt;
    end
endmodule // ecp_bridge

/* tb/tb.sv */
/* Self-checking bench for ecp_top with the bridge model on the legs.
   Assumes a 10 MHz clock and one-cycle APB answers. */
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb;
    logic        CLK = 1'b0;
    logic        RESET_N = 1'b0;
    logic        CE = 1'b1;
    logic        PSEL = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE = 1'b0;
    logic        STD4_OUT = 1'b0;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA, rd;
    logic [3:0]  PWM_OUT;
    logic        PREADY, PSLVERR, STD4_PIN, TRIG_ONE, TRIG_TWO, ADC_START, FIRST_TIMER_IF, THIRD_TIMER_IF;
    logic        err, seen, rdy, s;
    int          error_cnt = 0, n_checks = 0, per, hi, k, t, n;
    int unsigned d;

    ecp_top    ecp_top_i (.*);
    ecp_bridge ecp_bridge_i (.clk(CLK), .leg(PWM_OUT), .per(per), .hi(hi));

    initial forever #50 CLK = ~CLK;
    // Standard unit four output toggles at random
    always @(posedge CLK) STD4_OUT <= 1'($urandom);

    task end_sim;
        if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    function int pre(input int c);
        return c == 0 ? 1 : c == 1 ? 4 : 16;
    endfunction
    task cyc(input int c);
        repeat (c) @(posedge CLK);
    endtask
    // One APB transfer; ready, error and data are taken at the rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge CLK);
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, v};
        @(posedge CLK);
        PENABLE <= 1'b1;
        rdy = 1'b0;
        for (t = 0; t < 50 && rdy !== 1'b1; t++) begin
            @(posedge CLK);
            {rdy, err, rd} = {PREADY, PSLVERR, PRDATA};
        end
        if (rdy !== 1'b1) error_cnt++;
        {PSEL, PENABLE} <= 2'b00;
    endtask
    // Wait, bounded, for 1 trigger one, 2 converter start, 3 timer flag
    task hunt(input int w);
        seen = 1'b0;
        for (t = 0; t < 3000 && seen !== 1'b1; t++) begin
            @(negedge CLK);
            seen = w == 1 ? TRIG_ONE : w == 2 ? ADC_START : FIRST_TIMER_IF;
        end
    endtask
    // Count cycles in which leg A is off the level it must hold
    task lvl(input logic v);
        n = 0;
        repeat (40) begin
            @(negedge CLK);
            if (PWM_OUT[0] !== v) n++;
        end
    endtask

    initial begin
        #5000000;
        error_cnt++;
        end_sim;
    end

    initial begin
        void'($urandom(32838));
        cyc(3);
        RESET_N <= 1'b1;
        // Reset value, an unmapped place, control readback
        apb(1'b0, ecp_pkg::ADDR_CTRL1, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 8'h40, 32'h0);
        `CHK({err, rd}, 33'h100000000)
        apb(1'b1, ecp_pkg::ADDR_CTRL1, 32'hC2);
        apb(1'b0, ecp_pkg::ADDR_CTRL1, 32'h0);
        `CHK(rd[7:0], 8'hC2)
        apb(1'b1, ecp_pkg::ADDR_CTRL1, 32'h0);
        // Period and random duty at each prescale, changed while running
        apb(1'b1, ecp_pkg::ADDR_PERIOD, 32'h3);
        for (k = 0; k < 3; k++) begin
            d = $urandom_range(15, 1);
            apb(1'b1, ecp_pkg::ADDR_MISC, k);
            apb(1'b1, ecp_pkg::ADDR_DUTY, d >> 2);
            apb(1'b1, ecp_pkg::ADDR_CTRL3, 32'h0C | ((d & 3) << 4));
            cyc(80 * pre(k));
            `CHK(per, (3 + 1) * 4 * pre(k))
            `CHK(hi, d * pre(k))
        end
        // Duty beyond period, zero duty, inverted leg A
        apb(1'b1, ecp_pkg::ADDR_MISC, 32'h0);
        apb(1'b1, ecp_pkg::ADDR_DUTY, 32'hFF);
        apb(1'b1, ecp_pkg::ADDR_CTRL3, 32'h3C);
        cyc(80);
        lvl(1'b1);
        `CHK(n, 0)
        apb(1'b1, ecp_pkg::ADDR_DUTY, 32'h0);
        apb(1'b1, ecp_pkg::ADDR_CTRL3, 32'h0C);
        cyc(80);
        lvl(1'b0);
        `CHK(n, 0)
        apb(1'b1, ecp_pkg::ADDR_CTRL3, 32'h0E);
        cyc(80);
        lvl(1'b1);
        `CHK(n, 0)
        // Stall, then quad forward: leg D takes the shared pin, A held on
        @(posedge CLK);
        CE <= 1'b0;
        cyc(5);
        CE <= 1'b1;
        apb(1'b1, ecp_pkg::ADDR_DUTY, 32'h1);
        apb(1'b1, ecp_pkg::ADDR_CTRL3, 32'h6C);
        cyc(80);
        repeat (20) begin
            @(negedge CLK);
            `CHK({STD4_PIN, PWM_OUT[0]}, {PWM_OUT[3], 1'b1})
        end
        // Half bridge: B is the complement of A; reverse: C on, A and D off
        apb(1'b1, ecp_pkg::ADDR_CTRL3, 32'hAC);
        cyc(80);
        repeat (20) begin
            @(negedge CLK);
            `CHK(PWM_OUT[1], !PWM_OUT[0])
        end
        apb(1'b1, ecp_pkg::ADDR_CTRL3, 32'hEC);
        cyc(80);
        @(negedge CLK);
        `CHK({PWM_OUT[2], PWM_OUT[0], STD4_PIN}, 3'b100)
        // Back to single output: the standard unit owns its pin again
        apb(1'b1, ecp_pkg::ADDR_CTRL3, 32'h2C);
        cyc(80);
        @(negedge CLK);
        s = STD4_OUT;
        repeat (20) begin
            @(negedge CLK);
            `CHK(STD4_PIN, s)
            s = STD4_OUT;
        end
        // Unit one trigger caps each selectable timer at the compare pair
        apb(1'b1, ecp_pkg::ADDR_MISC, 32'h18);
        for (k = 0; k < 2; k++) begin
            apb(1'b1, ecp_pkg::ADDR_T3CTL, k << 3);
            d = $urandom_range(40, 8);
            apb(1'b1, ecp_pkg::ADDR_CMP1, d);
            // Restart the timer so it meets the pair well before wrapping
            apb(1'b1, k ? ecp_pkg::ADDR_TIMER3 : ecp_pkg::ADDR_TIMER1, 32'h0);
            apb(1'b1, ecp_pkg::ADDR_CTRL1, 32'h0B);
            hunt(1);
            `CHK(seen, 1'b1)
            repeat (3) begin
                apb(1'b0, k ? ecp_pkg::ADDR_TIMER3 : ecp_pkg::ADDR_TIMER1, 32'h0);
                `CHK(rd <= d, 1'b1)
            end
            apb(1'b1, ecp_pkg::ADDR_CTRL1, 32'h0);
        end
        // Unit two starts the converter only when enabled, sets no flag
        apb(1'b1, ecp_pkg::ADDR_T3CTL, 32'h0);
        apb(1'b1, ecp_pkg::ADDR_TIMER1, 32'h0);
        apb(1'b1, ecp_pkg::ADDR_CMP2, 32'h14);
        apb(1'b1, ecp_pkg::ADDR_MISC, 32'h1C);
        apb(1'b1, ecp_pkg::ADDR_CTRL2, 32'h0B);
        hunt(2);
        `CHK(seen, 1'b1)
        apb(1'b1, ecp_pkg::ADDR_MISC, 32'h18);
        hunt(2);
        `CHK(seen, 1'b0)
        `CHK(FIRST_TIMER_IF, 1'b0)
        // Without a trigger the timer overflows; a timer write clears the flag
        apb(1'b1, ecp_pkg::ADDR_CTRL2, 32'h0);
        apb(1'b1, ecp_pkg::ADDR_TIMER1, 32'hFFF0);
        hunt(3);
        `CHK(seen, 1'b1)
        apb(1'b1, ecp_pkg::ADDR_TIMER1, 32'h0);
        @(negedge CLK);
        `CHK(FIRST_TIMER_IF, 1'b0)
        // Second reset with the legs running
        @(posedge CLK);
        RESET_N <= 1'b0;
        cyc(3);
        RESET_N <= 1'b1;
        @(negedge CLK);
        `CHK(PWM_OUT, 4'h0)
        end_sim;
    end
endmodule // tb
